/* hw/sbap_pkg.sv */
package sbap_pkg;

	// APB address width: register index times four must fit
	localparam int          SBAP_PADDR_W     = 18;
	localparam int          SBAP_PDATA_W     = 32;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] SBAP_IDX_BYTE0   = 16'hF0E0;
	localparam logic [15:0] SBAP_IDX_BYTE1   = 16'hF0E1;
	localparam logic [15:0] SBAP_IDX_BYTE2   = 16'hF0E2;
	localparam logic [15:0] SBAP_IDX_BYTE3   = 16'hF0E3;
	localparam logic [15:0] SBAP_IDX_ADDR_LO = 16'hF0E4;
	localparam logic [15:0] SBAP_IDX_ADDR_HI = 16'hF0E5;
	localparam logic [15:0] SBAP_IDX_IRQ_SRC = 16'hF0E6;
	localparam logic [15:0] SBAP_IDX_IRQ_MSK = 16'hF0E7;

	// Buffer geometry
	localparam int          SBAP_BUF_ADDR_W  = 13;
	localparam int          SBAP_WORD_W      = 32;
	localparam int          SBAP_FIFO_DEPTH  = 8;

	// Fields of the high address / control register
	localparam int          SBAP_HI_DIR      = 7;
	localparam int          SBAP_HI_BUSY     = 6;
	localparam int          SBAP_HI_RSV      = 5;
	localparam int          SBAP_HI_ADDR_MSB = 4;

	// Fields of the first interrupt source register
	localparam int          SBAP_IRQ_DRIVE   = 0;
	localparam int          SBAP_IRQ_SECOND  = 1;
	localparam int          SBAP_IRQ_EVT_LSB = 2;
	localparam int          SBAP_IRQ_HDONE   = 3;
	localparam int          SBAP_IRQ_DDONE   = 5;

	// Reset values
	localparam logic [7:0]  SBAP_RST_BYTE    = 8'h00;
	localparam logic [12:0] SBAP_RST_PTR     = 13'h0000;

	// One buffered write: target address and assembled word
	typedef struct packed {
		logic [12:0] addr;
		logic [31:0] data;
	} sbap_wr_s;

	// Event pulses, packed in register order bits 7 down to 2
	typedef struct packed {
		logic normalCompletion;
		logic driveError;
		logic driveSideDone;
		logic hostSidePending;
		logic hostSideDone;
		logic byteCountMismatch;
	} sbap_evt_s;

	// Read prefetch sequencer
	typedef enum logic [1:0] {
		SBAP_FETCH_IDLE,
		SBAP_FETCH_REQ,
		SBAP_FETCH_WAIT
	} sbap_fetch_e;

endpackage : sbap_pkg

/* hw/sbap_access_port.sv */
// Summary of operation
// - Four byte data registers, reset zero
// - Thirteen-bit address split over low/high
// - Busy flag while fetching or storing
// - Direction bit: zero writes, one reads
// - Direction-one write fetches word, increments address
// - Bit five reserved, reads zero
// - Interrupt flags cleared by writing one
// - Command start clears both done flags
// - Interface flag set only in manual phase
// - Automatic phase services drive line silently
// - Bit one mirrors second-register pending sources
// - Bits seven to two are event flags
// - Mask register sits right after source
// - Byte three write in direction zero stores word, increments
// - Only byte three read triggers next prefetch
// - Mask bit one enables its source
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

// Write-word FIFO between the register port and the buffer memory
module sbap_fifo #(
	parameter int WIDTH = 45,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];  // Entry storage
	logic [PW-1:0]    wrIdx;          // Next slot to fill
	logic [PW-1:0]    rdIdx;          // Oldest slot
	logic [PW:0]      count;          // Entries held
	logic             push;
	logic             pop;

	// Honest flags straight from the count
	assign inReady  = (count < (PW+1)'(DEPTH)); // Room left while below depth
	assign outValid = (count != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = store[rdIdx];

	// One storage flop group per entry
	genvar e;
	generate
		for (e = 0; e < DEPTH; e++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					store[e] <= '0;
				end else if (push && (wrIdx == PW'(e))) begin
					store[e] <= inData;
				end
			end
		end
	endgenerate

	// Pointers wrap naturally; depth is a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrIdx <= '0;
			rdIdx <= '0;
		end else begin
			if (push) begin
				wrIdx <= wrIdx + 1'b1;
			end
			if (pop) begin
				rdIdx <= rdIdx + 1'b1;
			end
		end
	end

	// Occupancy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end

endmodule : sbap_fifo

// Register port to the sector buffer, with first interrupt source/mask pair
module sbap_access_port
	import sbap_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [SBAP_PADDR_W-1:0] paddr,
	input  wire logic [SBAP_PDATA_W-1:0] pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [SBAP_PDATA_W-1:0] prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Sector buffer memory port
	output logic                         memValid,
	output logic                         memWrite,
	output logic      [12:0]             memAddr,
	output logic      [31:0]             memWdata,
	input  wire logic                    memReady,
	input  wire logic [31:0]             memRdata,
	input  wire logic                    memRvalid,
	// Drive interface events, same clock
	input  wire sbap_evt_s               driveEvents,
	input  wire logic                    manualPhase,
	input  wire logic                    secondSourcePending,
	input  wire logic                    commandStartSet,
	// Drive interrupt request pin, asynchronous
	input  wire logic                    driveIntrqPin,
	// Flag and mask state for the interrupt vector logic
	output logic      [7:0]              irqSourceFlags,
	output logic      [7:0]              irqMaskBits
);

	// Register state
	logic [7:0]        dataByte [4];       // Data byte registers
	logic [12:0]       bufferAccessPointer; // Buffer address
	logic              bufferDirectionBit; // 1 = read from buffer
	logic [7:0]        irqSource;          // Source flags, bit 1 unused here
	logic              secondPendingFlag;  // Registered summary flag
	logic [7:0]        irqMask;            // Enables
	sbap_fetch_e       fetchState;         // Prefetch sequencer

	// Pin synchroniser and edge detect
	logic              intrqMeta;          // First stage, read only by next
	logic              intrqSync;          // Second stage
	logic              intrqLast;          // For edge detect

	// Bus decode
	logic [15:0]       regIdx;
	logic              mapped;
	logic              isData;
	logic              isAddr;
	logic              stall;
	logic              done;               // Access completes this edge
	logic              wrDone;
	logic              rdDone;
	logic              wrLane0;

	// FIFO hookup
	sbap_wr_s          fifoIn;
	sbap_wr_s          fifoOut;
	logic              fifoInValid;
	logic              fifoInReady;
	logic              fifoOutValid;
	logic              fifoOutReady;
	logic              fetchTrigger;
	logic              busyFlag;
	logic [7:0]        hiReadback;
	logic [7:0]        next_irqSource;
	logic [7:0]        clearMask;
	logic [7:0]        setMask;

	assign regIdx  = paddr[SBAP_PADDR_W-1:2];
	assign mapped  = (paddr[1:0] == 2'h0) && (regIdx >= SBAP_IDX_BYTE0)
	                 && (regIdx <= SBAP_IDX_IRQ_MSK);
	assign isData  = mapped && (regIdx <= SBAP_IDX_BYTE3);
	assign isAddr  = (regIdx == SBAP_IDX_ADDR_LO) || (regIdx == SBAP_IDX_ADDR_HI);
	assign done    = psel && penable && pready;
	assign wrDone  = done && pwrite && mapped;
	assign rdDone  = done && !pwrite && mapped;
	assign wrLane0 = pstrb[0];

	// Hold the bus while the data or address would be overtaken.
	// Polling the high register for busy never stalls.
	always_comb begin
		stall = 1'b0;
		if ((fetchState != SBAP_FETCH_IDLE) && (isData || (isAddr && pwrite))) begin
			stall = 1'b1;
		end
		if (pwrite && isAddr && fifoOutValid) begin
			stall = 1'b1; // Drain stores before the address moves
		end
		if (pwrite && (regIdx == SBAP_IDX_BYTE3) && !bufferDirectionBit && !fifoInReady) begin
			stall = 1'b1; // Back-pressure from a full FIFO
		end
	end

	// Ready one cycle into the access phase, data captured alongside
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready && !stall;
			pslverr <= psel && penable && !pready && !stall && !mapped;
		end
	end

	// High register readback; reserved bit forced low
	always_comb begin
		hiReadback                             = 8'h00;
		hiReadback[SBAP_HI_ADDR_MSB:0]         = bufferAccessPointer[12:8];
		hiReadback[SBAP_HI_RSV]                = 1'b0;
		hiReadback[SBAP_HI_BUSY]               = busyFlag;
		hiReadback[SBAP_HI_DIR]                = bufferDirectionBit;
	end

	// Read data register; reads outside the register index range give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (psel && penable && !pready) begin
			prdata <= '0;
			if (isData) begin
				prdata[7:0] <= dataByte[regIdx[1:0]];
			end else if (regIdx == SBAP_IDX_ADDR_LO) begin
				prdata[7:0] <= bufferAccessPointer[7:0];
			end else if (regIdx == SBAP_IDX_ADDR_HI) begin
				prdata[7:0] <= hiReadback;
			end else if (regIdx == SBAP_IDX_IRQ_SRC) begin
				prdata[7:0] <= irqSourceFlags;
			end else if (regIdx == SBAP_IDX_IRQ_MSK) begin
				prdata[7:0] <= irqMask;
			end
		end
	end

	// Data bytes: software writes, or a completed prefetch loads all four
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_byte
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					dataByte[b] <= SBAP_RST_BYTE;
				end else if ((fetchState == SBAP_FETCH_WAIT) && memRvalid) begin
					dataByte[b] <= memRdata[8*b +: 8];
				end else if (wrDone && wrLane0 && (regIdx == SBAP_IDX_BYTE0 + 16'(b))) begin
					dataByte[b] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// Direction bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bufferDirectionBit <= 1'b0;
		end else if (wrDone && wrLane0 && (regIdx == SBAP_IDX_ADDR_HI)) begin
			bufferDirectionBit <= pwdata[SBAP_HI_DIR];
		end
	end

	// Address pointer. Software writes restart the sequence; stores and
	// fetches step it, wrapping from the top back to zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bufferAccessPointer <= SBAP_RST_PTR;
		end else if (wrDone && wrLane0 && (regIdx == SBAP_IDX_ADDR_LO)) begin
			bufferAccessPointer[7:0] <= pwdata[7:0];
		end else if (wrDone && wrLane0 && (regIdx == SBAP_IDX_ADDR_HI)) begin
			bufferAccessPointer[12:8] <= pwdata[SBAP_HI_ADDR_MSB:0];
		end else if (fifoInValid && fifoInReady) begin
			bufferAccessPointer <= bufferAccessPointer + 13'h0001;
		end else if ((fetchState == SBAP_FETCH_WAIT) && memRvalid) begin
			bufferAccessPointer <= bufferAccessPointer + 13'h0001;
		end
	end

	// A byte three write in write direction queues the assembled word
	assign fifoInValid = wrDone && wrLane0 && (regIdx == SBAP_IDX_BYTE3)
	                     && !bufferDirectionBit;
	assign fifoIn.addr = bufferAccessPointer;
	assign fifoIn.data = {pwdata[7:0], dataByte[2], dataByte[1], dataByte[0]};

	// Prefetch starts on a direction-one high write or a final byte three read
	assign fetchTrigger = (wrDone && wrLane0 && (regIdx == SBAP_IDX_ADDR_HI)
	                       && pwdata[SBAP_HI_DIR])
	                      || (rdDone && (regIdx == SBAP_IDX_BYTE3)
	                       && bufferDirectionBit);

	sbap_fifo #(
		.WIDTH ($bits(sbap_wr_s)),
		.DEPTH (SBAP_FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOut)
	);

	// Memory port: stores drain first, a read waits for an empty FIFO
	// so it never sees stale contents
	always_comb begin
		memValid     = fifoOutValid;
		memWrite     = fifoOutValid;
		memAddr      = fifoOut.addr;
		memWdata     = fifoOut.data;
		fifoOutReady = memReady;
		if (!fifoOutValid && (fetchState == SBAP_FETCH_REQ)) begin
			memValid = 1'b1;
			memAddr  = bufferAccessPointer;
		end
	end

	// Prefetch sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetchState <= SBAP_FETCH_IDLE;
		end else begin
			case (fetchState)
				SBAP_FETCH_IDLE: begin
					if (fetchTrigger) begin
						fetchState <= SBAP_FETCH_REQ;
					end
				end
				SBAP_FETCH_REQ: begin
					if (!fifoOutValid && memReady) begin
						fetchState <= SBAP_FETCH_WAIT;
					end
				end
				SBAP_FETCH_WAIT: begin
					if (memRvalid) begin
						fetchState <= SBAP_FETCH_IDLE;
					end
				end
				default: begin
					fetchState <= SBAP_FETCH_IDLE;
				end
			endcase
		end
	end

	// Busy covers queued stores and any fetch in flight
	assign busyFlag = fifoOutValid || (fetchState != SBAP_FETCH_IDLE);

	// Drive interrupt pin synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intrqMeta <= 1'b0;
			intrqSync <= 1'b0;
			intrqLast <= 1'b0;
		end else begin
			intrqMeta <= driveIntrqPin;
			intrqSync <= intrqMeta;
			intrqLast <= intrqSync;
		end
	end

	// Flag update: set wins over any clear in the same cycle
	always_comb begin
		setMask   = 8'h00;
		clearMask = 8'h00;
		setMask[7:SBAP_IRQ_EVT_LSB] = driveEvents;
		// Automatic phase leaves the flag alone; the sequencer owns the line
		setMask[SBAP_IRQ_DRIVE] = intrqSync && !intrqLast && manualPhase;
		if (wrDone && wrLane0 && (regIdx == SBAP_IDX_IRQ_SRC)) begin
			clearMask = pwdata[7:0];
		end
		if (commandStartSet) begin
			clearMask[SBAP_IRQ_HDONE] = 1'b1;
			clearMask[SBAP_IRQ_DDONE] = 1'b1;
		end
		clearMask[SBAP_IRQ_SECOND] = 1'b0;
		setMask[SBAP_IRQ_SECOND]   = 1'b0;
		next_irqSource = (irqSource & ~clearMask) | setMask;
	end

	// Source flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqSource <= SBAP_RST_BYTE;
		end else begin
			irqSource <= next_irqSource;
		end
	end

	// Summary flag follows the second register's pending state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondPendingFlag <= 1'b0;
		end else begin
			secondPendingFlag <= secondSourcePending;
		end
	end

	// Mask register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqMask <= SBAP_RST_BYTE;
		end else if (wrDone && wrLane0 && (regIdx == SBAP_IDX_IRQ_MSK)) begin
			irqMask <= pwdata[7:0];
		end
	end

	// Flag view: read-only summary bit merged in
	always_comb begin
		irqSourceFlags                  = irqSource;
		irqSourceFlags[SBAP_IRQ_SECOND] = secondPendingFlag;
	end

	assign irqMaskBits = irqMask;

endmodule : sbap_access_port

/* dv/sbap_access_port_sva.sv */
`timescale 1ns/1ps

// Port-level checker for the buffer access port
module sbap_access_port_sva
	import sbap_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        memValid,
	input wire logic        memWrite,
	input wire logic [12:0] memAddr,
	input wire logic [31:0] memWdata,
	input wire logic        memReady,
	input wire sbap_evt_s   driveEvents,
	input wire logic        manualPhase,
	input wire logic        secondSourcePending,
	input wire logic        commandStartSet,
	input wire logic [7:0]  irqSourceFlags,
	input wire logic [7:0]  irqMaskBits
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [15:0] idx;    // Register index of the access
	logic        wrDone; // Write taking effect this edge
	assign idx    = paddr[17:2];
	assign wrDone = psel && penable && pready && pwrite && pstrb[0];

	AST_RSV_ZERO:
		assert property (pready && !pwrite && idx == SBAP_IDX_ADDR_HI |->
			!prdata[SBAP_HI_RSV] && prdata[31:8] == 24'h000000)
		else $error("reserved high bit read as one");
	// Registered one cycle, so skip the edge just after reset
	AST_PEND_MIRROR:
		assert property ($past(rst_n) |->
			irqSourceFlags[SBAP_IRQ_SECOND] == $past(secondSourcePending))
		else $error("pending summary bit does not follow input");
	// Pin path is synchronised, so look a few cycles back
	AST_DRIVE_MANUAL:
		assert property ($rose(irqSourceFlags[SBAP_IRQ_DRIVE]) |-> $past(manualPhase)
			|| $past(manualPhase, 2) || $past(manualPhase, 3) || $past(manualPhase, 4))
		else $error("interface flag set outside manual phase");
	AST_W1C:
		assert property (wrDone && idx == SBAP_IDX_IRQ_SRC && pwdata[7]
			&& !driveEvents.normalCompletion |=> !irqSourceFlags[7])
		else $error("write one did not clear flag");
	AST_START_CLR:
		assert property (commandStartSet && !driveEvents.hostSideDone
			&& !driveEvents.driveSideDone |=> !irqSourceFlags[SBAP_IRQ_HDONE]
			&& !irqSourceFlags[SBAP_IRQ_DDONE])
		else $error("command start left a done flag set");
	AST_EVT_SET:
		assert property (driveEvents != 6'h00 |=>
			(irqSourceFlags[7:2] & $past(driveEvents)) == $past(driveEvents))
		else $error("event pulse not recorded");
	AST_MASK_WR:
		assert property (wrDone && idx == SBAP_IDX_IRQ_MSK |=>
			irqMaskBits == $past(pwdata[7:0]))
		else $error("mask write lost");
	// A waiting store must not change under the memory
	AST_STORE_HOLD:
		assert property (memValid && !memReady |=> memValid && $stable(memWrite)
			&& $stable(memAddr) && $stable(memWdata))
		else $error("memory request changed while waiting");
endmodule : sbap_access_port_sva

bind sbap_access_port sbap_access_port_sva u_sva (.clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .memValid, .memWrite, .memAddr, .memWdata,
	.memReady, .driveEvents, .manualPhase, .secondSourcePending, .commandStartSet,
	.irqSourceFlags, .irqMaskBits);

/* dv/sbap_access_port_tb.sv */
`timescale 1ns/1ps

// Self-checking bench for the buffer access port
module sbap_access_port_tb
	import sbap_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, slv;
	logic        memValid, memWrite, memReady, memRvalid, stall;
	logic        manualPhase, secondSourcePending, commandStartSet, driveIntrqPin;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, memWdata, memRdata, rd;
	logic [3:0]  pstrb;
	logic [12:0] memAddr;
	logic [7:0]  irqSourceFlags, irqMaskBits;
	sbap_evt_s   driveEvents;
	logic [31:0] mem [0:8191]; // Buffer memory stand-in
	int          error_cnt, tests_run, cyc, nc;

	sbap_access_port u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .memValid, .memWrite, .memAddr, .memWdata, .memReady,
		.memRdata, .memRvalid, .driveEvents, .manualPhase, .secondSourcePending,
		.commandStartSet, .driveIntrqPin, .irqSourceFlags, .irqMaskBits);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Memory answers every other cycle; stall holds it off to fill the queue
	always @(posedge clk) begin
		memReady <= !stall && !memReady;
		if (memValid && memReady && !memWrite) begin
			memRvalid <= 1'b1;
			memRdata  <= mem[memAddr];
		end else begin
			memRvalid <= 1'b0;
			memRdata  <= ~memRdata; // Never a stale word outside answers
		end
		if (memValid && memReady && memWrite)
			mem[memAddr] <= memWdata;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			wrap_up();
		end
	end

	function automatic logic [31:0] pat(input logic [12:0] a);
		return {3'h5, a, 3'h2, a};
	endfunction : pat

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One transfer, held until pready, then one idle cycle
	task apb(input logic w, input logic [15:0] ix, input logic [7:0] d);
		nc = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {ix, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			nc++;
		end while (pready !== 1'b1); // Only the hang guard ends a wait
		rd  = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task wr(input logic [15:0] ix, input logic [7:0] d);
		apb(1'b1, ix, d);
	endtask : wr

	task rdc(input string nm, input logic [15:0] ix, input logic [7:0] exp);
		apb(1'b0, ix, 8'h00);
		check(nm, rd, {24'h000000, exp});
	endtask : rdc

	// Poll busy; busy reads are never stalled
	task waitIdle();
		do begin
			apb(1'b0, SBAP_IDX_ADDR_HI, 8'h00);
		end while (rd[SBAP_HI_BUSY] !== 1'b0);
	endtask : waitIdle

	task t_regs();
		for (int i = 0; i < 8; i++)
			rdc("reset", SBAP_IDX_BYTE0 + 16'(i), 8'h00);
		wr(SBAP_IDX_BYTE2, 8'h5A);
		rdc("byte2", SBAP_IDX_BYTE2, 8'h5A);
		wr(SBAP_IDX_ADDR_HI, 8'h7F);
		rdc("addrHi", SBAP_IDX_ADDR_HI, 8'h1F);
		apb(1'b0, 16'hF0E8, 8'h00);
		check("unmappedErr", 32'(slv), 32'h00000001);
		check("unmappedData", rd, 32'h00000000);
	endtask : t_regs

	// Two stores across the top of the address range
	task t_write();
		wr(SBAP_IDX_ADDR_LO, 8'hFF);
		wr(SBAP_IDX_ADDR_HI, 8'h1F);
		for (int w = 0; w < 2; w++)
			for (int b = 0; b < 4; b++)
				wr(SBAP_IDX_BYTE0 + 16'(b), 8'(16 * w + b + 1));
		waitIdle();
		check("lastWord", mem[13'h1FFF], 32'h04030201);
		check("wrapWord", mem[13'h0000], 32'h14131211);
		rdc("ptrLo", SBAP_IDX_ADDR_LO, 8'h01);
	endtask : t_write

	// Fill the queue with memory stalled until byte 3 is refused
	task t_fifo();
		stall <= 1'b1;
		wr(SBAP_IDX_ADDR_LO, 8'h20);
		wr(SBAP_IDX_ADDR_HI, 8'h00);
		for (int k = 0; k < 9; k++) begin
			if (k == 8) begin
				rdc("busyFull", SBAP_IDX_ADDR_HI, 8'h40);
				fork
					begin
						repeat (40) @(posedge clk);
						stall <= 1'b0;
					end
				join_none
			end
			for (int b = 0; b < 4; b++)
				wr(SBAP_IDX_BYTE0 + 16'(b), 8'(k + 64));
		end
		check("fullStall", 32'(nc > 12), 32'h00000001);
		waitIdle();
		for (int k = 0; k < 9; k++)
			check("queued", mem[13'(32 + k)], {4{8'(k + 64)}});
	endtask : t_fifo

	// Direction one fetches; only a byte 3 read fetches again
	task t_read();
		wr(SBAP_IDX_ADDR_LO, 8'h05);
		wr(SBAP_IDX_ADDR_HI, 8'h80);
		waitIdle();
		for (int k = 0; k < 2; k++)
			for (int b = 0; b < 4; b++)
				rdc("fetch", SBAP_IDX_BYTE0 + 16'(b), 8'(pat(13'(5 + k)) >> (8 * b)));
		rdc("partial", SBAP_IDX_BYTE1, 8'(pat(13'h0007) >> 8));
		rdc("partial", SBAP_IDX_BYTE1, 8'(pat(13'h0007) >> 8));
		rdc("ptrAfter", SBAP_IDX_ADDR_LO, 8'h08);
	endtask : t_read

	task t_irq();
		driveEvents <= 6'h3F;
		@(posedge clk);
		driveEvents <= 6'h00;
		rdc("events", SBAP_IDX_IRQ_SRC, 8'hFC);
		wr(SBAP_IDX_IRQ_SRC, 8'h92);
		rdc("w1c", SBAP_IDX_IRQ_SRC, 8'h6C);
		commandStartSet <= 1'b1;
		@(posedge clk);
		commandStartSet     <= 1'b0;
		secondSourcePending <= 1'b1;
		@(posedge clk);
		rdc("start", SBAP_IDX_IRQ_SRC, 8'h46);
		driveIntrqPin <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("autoPhase", SBAP_IDX_IRQ_SRC, 8'h46);
		driveIntrqPin <= 1'b0;
		manualPhase   <= 1'b1;
		repeat (8) @(posedge clk);
		driveIntrqPin <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("manual", SBAP_IDX_IRQ_SRC, 8'h47);
		wr(SBAP_IDX_IRQ_SRC, 8'hFF);
		rdc("allClear", SBAP_IDX_IRQ_SRC, 8'h02);
		wr(SBAP_IDX_IRQ_MSK, 8'hA5);
		rdc("mask", SBAP_IDX_IRQ_MSK, 8'hA5);
	endtask : t_irq

	task wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		rst_n               = 1'b0;
		psel                = 1'b0;
		penable             = 1'b0;
		pwrite              = 1'b0;
		paddr               = 18'h00000;
		pwdata              = 32'h00000000;
		pstrb               = 4'hF;
		memReady            = 1'b0;
		memRvalid           = 1'b0;
		memRdata            = 32'h00000000;
		stall               = 1'b0;
		manualPhase         = 1'b0;
		secondSourcePending = 1'b0;
		commandStartSet     = 1'b0;
		driveIntrqPin       = 1'b0;
		driveEvents         = 6'h00;
		error_cnt           = 0;
		tests_run           = 0;
		cyc                 = 0;
		for (int i = 0; i < 8192; i++)
			mem[i] = pat(13'(i));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_write();
		t_fifo();
		t_read();
		t_irq();
		wrap_up();
	end
endmodule : sbap_access_port_tb
